// ===== rtl/dual_reload_down_timer.sv
// Dual 8-bit reload down timer with cascade, event count and APB access
`timescale 1ns/10ps
module dual_reload_down_timer #(
  parameter int unsigned LSO_HZ = tmr_pkg::LSO_HZ,
  parameter int unsigned NOISE_HZ = tmr_pkg::NOISE_HZ
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc,
  input wire logic high_speed_osc,
  input wire logic event_input_pin,
  output logic toggle_output_pin,
  output logic inverted_toggle_pin,
  output logic underflow_ch0,
  output logic underflow_ch1
);

  // -------------------------------------------------------------------
  // Derived constants
  // -------------------------------------------------------------------
  localparam int unsigned NOISE_DIV = LSO_HZ / NOISE_HZ;
  localparam int unsigned NDIV_W = (NOISE_DIV > 1) ? $clog2(NOISE_DIV) : 1;
  localparam logic [NDIV_W-1:0] NDIV_LAST = NDIV_W'(NOISE_DIV - 1);

  // Last prescaler count for a division code
  function automatic logic [5:0] psc_last(input logic [1:0] code);
    unique case (code)
      tmr_pkg::PSC_DIV64: psc_last = tmr_pkg::LAST_DIV64;
      tmr_pkg::PSC_DIV16: psc_last = tmr_pkg::LAST_DIV16;
      tmr_pkg::PSC_DIV4: psc_last = tmr_pkg::LAST_DIV4;
      tmr_pkg::PSC_DIV1: psc_last = tmr_pkg::LAST_DIV1;
    endcase
  endfunction

  // One prescaler step: advance on an enabled source edge, tick on wrap
  function automatic tmr_pkg::psc_res_s psc_step(input logic [5:0] cnt,
      input logic [1:0] code, input logic en);
    tmr_pkg::psc_res_s r;
    r.tick = 1'b0;
    r.cnt = cnt;
    if (en) begin
      if (cnt >= psc_last(code)) begin
        r.tick = 1'b1;
        r.cnt = 6'h00;
      end else begin
        r.cnt = cnt + 6'h01;
      end
    end
    return r;
  endfunction

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;
  logic [NDIV_W-1:0] ndiv_q, ndiv_d;
  logic evt_q, evt_d;
  logic [1:0] fcnt_q, fcnt_d;
  logic [5:0] psc0_q, psc0_d, psc1_q, psc1_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic [7:0] ch0_q, ch0_d, ch1_q, ch1_d;
  logic [7:0] rld0_q, rld0_d, rld1_q, rld1_d;
  logic [7:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;
  logic tog_q, tog_d, inv_q, inv_d;
  logic uf0_q, uf0_d, uf1_q, uf1_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  // Combinational helpers
  logic [2:0] fall;
  logic ntick, ev_edge, casc, ext;
  logic src0_tick, src1_tick, tick0, tick1;
  logic wr_en, wr_ctrl, wr_ch0, wr_ch1, wr_rld;
  logic pre0, pre1, uf0_ev, uf1_ev, uf16_ev, halved_underflow_out_ev;
  logic [15:0] val16;
  tmr_pkg::psc_res_s p0, p1;

  // -------------------------------------------------------------------
  // Input synchronisers and noise filter
  // -------------------------------------------------------------------
  // Three stages per pin; level accepted once stages two and three agree
  always_comb begin
    s1_d = {event_input_pin, high_speed_osc, low_speed_osc};
    s2_d = s1_q;
    s3_d = s2_q;
    for (int i = 0; i < int'(tmr_pkg::SYN_N); i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
    fall = lvl_q & ~lvl_d;
  end

  // Internal 2,048 Hz tick from the low-speed oscillator's falling edges
  always_comb begin
    ndiv_d = ndiv_q;
    ntick = 1'b0;
    if (fall[tmr_pkg::SYN_LSO]) begin
      if (ndiv_q == NDIV_LAST) begin
        ndiv_d = '0;
        ntick = 1'b1;
      end else begin
        ndiv_d = ndiv_q + NDIV_W'(1);
      end
    end
  end

  // Event level, optionally passed through the noise filter
  always_comb begin
    evt_d = evt_q;
    fcnt_d = 2'h0;
    if (!ch0_q[tmr_pkg::CH_FILT]) begin
      evt_d = lvl_q[tmr_pkg::SYN_EVT];
    end else if (lvl_q[tmr_pkg::SYN_EVT] != evt_q) begin
      fcnt_d = fcnt_q;
      if (ntick) begin
        if (fcnt_q == tmr_pkg::FILTER_LAST) begin
          evt_d = lvl_q[tmr_pkg::SYN_EVT];
          fcnt_d = 2'h0;
        end else begin
          fcnt_d = fcnt_q + 2'h1;
        end
      end
    end
    // Counting edge of the accepted event level
    ev_edge = ch0_q[tmr_pkg::CH_EDGE] ? (~evt_q & evt_d)
                                      : (evt_q & ~evt_d);
  end

  // -------------------------------------------------------------------
  // Clock selection and prescalers
  // -------------------------------------------------------------------
  always_comb begin
    casc = ctrl_q[tmr_pkg::CTRL_CASCADE];
    ext = ch0_q[tmr_pkg::CH_EXT];
    src0_tick = ctrl_q[tmr_pkg::CTRL_SRC0] ? fall[tmr_pkg::SYN_HSO]
                                           : fall[tmr_pkg::SYN_LSO];
    src1_tick = ctrl_q[tmr_pkg::CTRL_SRC1] ? fall[tmr_pkg::SYN_HSO]
                                           : fall[tmr_pkg::SYN_LSO];
    // Source reaches a prescaler only while its run bit is set
    p0 = psc_step(psc0_q, ch0_q[tmr_pkg::CH_PSC_HI:tmr_pkg::CH_PSC_LO],
                  ch0_q[tmr_pkg::CH_RUN] & src0_tick & ~ext);
    p1 = psc_step(psc1_q, ch1_q[tmr_pkg::CH_PSC_HI:tmr_pkg::CH_PSC_LO],
                  ch1_q[tmr_pkg::CH_RUN] & src1_tick & ~casc);
    psc0_d = p0.cnt;
    psc1_d = p1.cnt;
    // Event mode bypasses the prescaler of timer 0
    tick0 = ext ? (ch0_q[tmr_pkg::CH_RUN] & ev_edge)
                : p0.tick;
    tick1 = p1.tick & ~casc;
  end

  // -------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------
  // Writes take effect at the edge where the master sees pready high
  always_comb begin
    wr_en = psel & penable & pready_q & pwrite;
    wr_ctrl = wr_en & (paddr == tmr_pkg::OFS_CTRL);
    wr_ch0 = wr_en & (paddr == tmr_pkg::OFS_CH0);
    wr_ch1 = wr_en & (paddr == tmr_pkg::OFS_CH1);
    wr_rld = wr_en & (paddr == tmr_pkg::OFS_RELOAD);
    pre0 = wr_ch0 & pwdata[tmr_pkg::CH_PRESET];
    pre1 = wr_ch1 & pwdata[tmr_pkg::CH_PRESET] & ~casc;
  end

  // Answer one cycle into the access phase; read data sampled then
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        tmr_pkg::OFS_CTRL: prdata_d[tmr_pkg::CTRL_W-1:0] = ctrl_q;
        tmr_pkg::OFS_CH0: prdata_d[tmr_pkg::CH_W-1:0] = ch0_q;
        tmr_pkg::OFS_CH1: prdata_d[tmr_pkg::CH_W-1:0] = ch1_q;
        tmr_pkg::OFS_RELOAD: prdata_d[15:0] = {rld1_q, rld0_q};
        tmr_pkg::OFS_COUNT: prdata_d[15:0] = {cnt1_q, cnt0_q};
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Down counters, run control and underflow
  // -------------------------------------------------------------------
  always_comb begin
    val16 = {cnt1_q, cnt0_q};
    cnt0_d = cnt0_q;
    cnt1_d = cnt1_q;
    uf0_ev = 1'b0;
    uf1_ev = 1'b0;
    uf16_ev = 1'b0;
    if (casc) begin
      // Low byte borrows into high byte; reload on 16-bit underflow
      if (pre0) begin
        {cnt1_d, cnt0_d} = {rld1_q, rld0_q};
      end else if (tick0) begin
        if (val16 == 16'h0000) begin
          {cnt1_d, cnt0_d} = {rld1_q, rld0_q};
          uf16_ev = 1'b1;
        end else begin
          {cnt1_d, cnt0_d} = val16 - 16'h0001;
        end
      end
    end else begin
      // Two independent 8-bit channels
      if (pre0) begin
        cnt0_d = rld0_q;
      end else if (tick0) begin
        uf0_ev = (cnt0_q == 8'h00);
        cnt0_d = uf0_ev ? rld0_q : cnt0_q - 8'h01;
      end
      if (pre1) begin
        cnt1_d = rld1_q;
      end else if (tick1) begin
        uf1_ev = (cnt1_q == 8'h00);
        cnt1_d = uf1_ev ? rld1_q : cnt1_q - 8'h01;
      end
    end
  end

  // Control registers; a software write wins over a one-shot stop
  always_comb begin
    ctrl_d = ctrl_q;
    ch0_d = ch0_q;
    ch1_d = ch1_q;
    rld0_d = rld0_q;
    rld1_d = rld1_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata[tmr_pkg::CTRL_W-1:0];
    end
    if (wr_ch0) begin
      ch0_d = pwdata[tmr_pkg::CH_W-1:0];
      ch0_d[tmr_pkg::CH_PRESET] = 1'b0; // Strobe holds nothing
    end else if ((uf0_ev | uf16_ev) && !ch0_q[tmr_pkg::CH_CONT]) begin
      ch0_d[tmr_pkg::CH_RUN] = 1'b0;
    end
    if (wr_ch1) begin
      ch1_d = pwdata[tmr_pkg::CH_W-1:0];
      ch1_d[tmr_pkg::CH_PRESET] = 1'b0;
      ch1_d[tmr_pkg::CH_W-1:tmr_pkg::CH_EDGE] = '0; // No event logic
    end else if (uf1_ev && !ch1_q[tmr_pkg::CH_CONT]) begin
      ch1_d[tmr_pkg::CH_RUN] = 1'b0;
    end
    if (casc) begin
      ch1_d[tmr_pkg::CH_RUN] = 1'b0;
    end
    if (wr_rld) begin
      rld0_d = pwdata[7:0];
      rld1_d = pwdata[15:8];
    end
  end

  // Underflow pulses and the halved toggle output
  always_comb begin
    uf0_d = uf0_ev;
    uf1_d = uf1_ev | uf16_ev;
    halved_underflow_out_ev = (casc | ctrl_q[tmr_pkg::CTRL_HALVED_UNDERFLOW_OUT_SEL]) ? (uf1_ev | uf16_ev)
                                                      : uf0_ev;
    tog_d = tog_q ^ halved_underflow_out_ev;
    inv_d = ~tog_d;
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      lvl_q <= 3'h0;
      ndiv_q <= '0;
      evt_q <= 1'b0;
      fcnt_q <= 2'h0;
      psc0_q <= 6'h00;
      psc1_q <= 6'h00;
      ctrl_q <= tmr_pkg::CTRL_RST;
      ch0_q <= tmr_pkg::CH_RST;
      ch1_q <= tmr_pkg::CH_RST;
      rld0_q <= tmr_pkg::RELOAD_RST;
      rld1_q <= tmr_pkg::RELOAD_RST;
      cnt0_q <= tmr_pkg::CNT_RST;
      cnt1_q <= tmr_pkg::CNT_RST;
      tog_q <= 1'b0;
      inv_q <= 1'b1;
      uf0_q <= 1'b0;
      uf1_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
      ndiv_q <= ndiv_d;
      evt_q <= evt_d;
      fcnt_q <= fcnt_d;
      psc0_q <= psc0_d;
      psc1_q <= psc1_d;
      ctrl_q <= ctrl_d;
      ch0_q <= ch0_d;
      ch1_q <= ch1_d;
      rld0_q <= rld0_d;
      rld1_q <= rld1_d;
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
      tog_q <= tog_d;
      inv_q <= inv_d;
      uf0_q <= uf0_d;
      uf1_q <= uf1_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign toggle_output_pin = tog_q;
  assign inverted_toggle_pin = inv_q;
  assign underflow_ch0 = uf0_q;
  assign underflow_ch1 = uf1_q;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  AST_PRESET: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && pre0 && !casc) |=> (cnt0_q == $past(rld0_q)))
    else $error("preset did not load reload value");

  AST_STOP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    (!ch0_q[tmr_pkg::CH_RUN] && !pre0 && !casc) |=> $stable(cnt0_q))
    else $error("stopped counter changed");

  AST_RELOAD: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && tick0 && !pre0 && !casc && cnt0_q == 8'h00)
    |=> (cnt0_q == $past(rld0_q)) ##0 underflow_ch0)
    else $error("underflow did not reload and pulse");

  AST_ONESHOT: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && uf0_ev && !ch0_q[tmr_pkg::CH_CONT] && !wr_ch0)
    |=> !ch0_q[tmr_pkg::CH_RUN])
    else $error("one-shot did not clear run");

  AST_CONT: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && uf0_ev && ch0_q[tmr_pkg::CH_CONT] && !wr_ch0)
    |=> ch0_q[tmr_pkg::CH_RUN])
    else $error("continuous mode stopped");

  AST_CASC_RUN1: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && casc) |=> !ch1_q[tmr_pkg::CH_RUN])
    else $error("timer 1 runs in cascade");

  AST_TOGGLE: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && halved_underflow_out_ev) |=> (toggle_output_pin != $past(toggle_output_pin))
    && (inverted_toggle_pin == !toggle_output_pin))
    else $error("toggle output did not flip");

  AST_GATE: assert property (@(posedge mclk) disable iff (!rstn)
    !ch0_q[tmr_pkg::CH_RUN] |=> $stable(psc0_q))
    else $error("prescaler moved while stopped");

  AST_CASC_BORROW: assert property (@(posedge mclk)
    disable iff (!rstn)
    (ce && casc && tick0 && !pre0 && cnt0_q == 8'h00 && cnt1_q != 8'h00)
    |=> (cnt0_q == 8'hFF) && (cnt1_q == $past(cnt1_q) - 8'h01))
    else $error("low byte borrow not passed to high byte");

  AST_APB_READY: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not a single cycle after one wait");

endmodule

// ===== rtl/tmr_pkg.sv
// Constants, field layouts and carrier types of the dual reload timer
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package tmr_pkg;

  // -------------------------------------------------------------------
  // Register offsets (byte addresses)
  // -------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CH0 = 12'h004;
  localparam logic [11:0] OFS_CH1 = 12'h008;
  localparam logic [11:0] OFS_RELOAD = 12'h00C;
  localparam logic [11:0] OFS_COUNT = 12'h010;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int unsigned CTRL_CASCADE = 0;
  localparam int unsigned CTRL_HALVED_UNDERFLOW_OUT_SEL = 1;
  localparam int unsigned CTRL_SRC0 = 2;
  localparam int unsigned CTRL_SRC1 = 3;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CH_RUN = 0;
  localparam int unsigned CH_PRESET = 1;
  localparam int unsigned CH_CONT = 2;
  localparam int unsigned CH_PSC_LO = 3;
  localparam int unsigned CH_PSC_HI = 4;
  localparam int unsigned CH_EDGE = 5;
  localparam int unsigned CH_FILT = 6;
  localparam int unsigned CH_EXT = 7;
  localparam int unsigned CH_W = 8;
  localparam int unsigned CNT_W = 8;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] CH_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'hFF;
  localparam logic [7:0] CNT_RST = 8'h00;

  // -------------------------------------------------------------------
  // Prescaler codes and last count of each division
  // -------------------------------------------------------------------
  localparam logic [1:0] PSC_DIV1 = 2'h0;
  localparam logic [1:0] PSC_DIV4 = 2'h1;
  localparam logic [1:0] PSC_DIV16 = 2'h2;
  localparam logic [1:0] PSC_DIV64 = 2'h3;
  localparam logic [5:0] LAST_DIV1 = 6'h00;
  localparam logic [5:0] LAST_DIV4 = 6'h03;
  localparam logic [5:0] LAST_DIV16 = 6'h0F;
  localparam logic [5:0] LAST_DIV64 = 6'h3F;

  // -------------------------------------------------------------------
  // Noise filter timing
  // -------------------------------------------------------------------
  localparam int unsigned LSO_HZ = 32768;
  localparam int unsigned NOISE_HZ = 2048;
  localparam logic [1:0] FILTER_LAST = 2'h1; // Second 2,048 Hz edge

  // Synchroniser lanes
  localparam int unsigned SYN_LSO = 0;
  localparam int unsigned SYN_HSO = 1;
  localparam int unsigned SYN_EVT = 2;
  localparam int unsigned SYN_N = 3;

  // Result of one prescaler step
  typedef struct packed {
    logic tick;
    logic [5:0] cnt;
  } psc_res_s;

endpackage

// ===== tb/osc_event_source.sv
// Oscillator and event pin source standing beside the timer
`timescale 1ns/10ps
module osc_event_source (
  input wire logic mclk,
  output logic low_speed_osc,
  output logic high_speed_osc,
  output logic event_input_pin
);
  // ---------------------------------------------------------------
  // Idle levels: both clocks stand high until pulsed
  // ---------------------------------------------------------------
  initial begin
    low_speed_osc = 1'h1;
    high_speed_osc = 1'h1; // Kept still until software wants it
    event_input_pin = 1'h1;
  end

  // Falling edges on command, each level held four mclk cycles
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      if (sel == 0) low_speed_osc <= 1'h0;
      else high_speed_osc <= 1'h0;
      repeat (4) @(posedge mclk);
      if (sel == 0) low_speed_osc <= 1'h1;
      else high_speed_osc <= 1'h1;
      repeat (4) @(posedge mclk);
    end
  endtask

  // New event level, held for the given number of cycles
  task automatic level(input logic v, input int hold);
    event_input_pin <= v;
    repeat (hold) @(posedge mclk);
  endtask
endmodule

// ===== tb/dual_reload_down_timer_bench.sv
// Self-checking bench of the dual reload down timer
`timescale 1ns/10ps
module dual_reload_down_timer_bench;
  // ---------------------------------------------------------------
  // Signals and reference model state
  // ---------------------------------------------------------------
  logic mclk = 1'h0, rstn = 1'h0, ce = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, err, low_speed_osc, high_speed_osc;
  logic event_input_pin, toggle_output_pin, inverted_toggle_pin;
  logic underflow_ch0, underflow_ch1;
  int cnt[2], rld[2], run[2], cont[2], psc[2], src[2], pc[2], uf[2];
  int casc, tsel, ext, tog, num_errors, checks, cyc, seen0, seen1;

  always #10 mclk = ~mclk;

  dual_reload_down_timer #(.LSO_HZ(4096), .NOISE_HZ(2048))
      dual_reload_down_timer_i (.mclk, .rstn, .ce, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .low_speed_osc,
      .high_speed_osc, .event_input_pin, .toggle_output_pin,
      .inverted_toggle_pin, .underflow_ch0, .underflow_ch1);
  osc_event_source osc_event_source_i (.mclk, .low_speed_osc,
      .high_speed_osc, .event_input_pin);

  // Underflow pulse counts and the hang limit
  always @(posedge mclk) begin
    cyc++;
    if (underflow_ch0 === 1'h1) seen0++;
    if (underflow_ch1 === 1'h1) seen1++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic void mtick(int ch);
    int v;
    v = casc ? cnt[1] * 256 + cnt[0] : cnt[ch];
    if (v == 0) begin
      v = casc ? rld[1] * 256 + rld[0] : rld[ch];
      uf[casc ? 1 : ch]++;
      if (casc || tsel == ch) tog ^= 1;
      if (cont[ch] == 0) run[ch] = 0;
    end else v--;
    if (casc) begin
      cnt[0] = v % 256;
      cnt[1] = v / 256;
    end else cnt[ch] = v;
  endfunction

  function automatic void medge(int s);
    for (int ch = 0; ch < 2; ch++) begin
      if (run[ch] && src[ch] == s && !(ch == 0 && ext) && !(ch && casc)) begin
        pc[ch]++;
        if (pc[ch] >= (1 << (2 * psc[ch]))) begin
          pc[ch] = 0;
          mtick(ch);
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Bus, compare and stimulus tasks
  // ---------------------------------------------------------------
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wctrl(logic [3:0] v);
    apb(1, tmr_pkg::OFS_CTRL, {28'h0, v});
    casc = v[0];
    tsel = v[1];
    src[0] = v[2];
    src[1] = v[3];
    if (casc) run[1] = 0;
  endtask

  task automatic wch(int ch, logic [7:0] v);
    apb(1, ch ? tmr_pkg::OFS_CH1 : tmr_pkg::OFS_CH0, {24'h0, v});
    if (!(ch && casc)) begin
      run[ch] = v[0];
      if (v[1] && casc) cnt = rld;
      else if (v[1]) cnt[ch] = rld[ch];
    end
    cont[ch] = v[2];
    psc[ch] = v[4:3];
    if (ch == 0) ext = v[7];
  endtask

  task automatic wrld(int r0, int r1);
    apb(1, tmr_pkg::OFS_RELOAD, 32'((r1 << 8) | r0));
    rld[0] = r0;
    rld[1] = r1;
  endtask

  task automatic pl(int s, int n);
    repeat (n) begin
      osc_event_source_i.pulse(s, 1);
      medge(s);
    end
  endtask

  task automatic mcmp();
    repeat (8) @(posedge mclk);
    apb(0, tmr_pkg::OFS_COUNT, 32'h0);
    chk("count", rd, cnt[1] * 256 + cnt[0]);
    apb(0, tmr_pkg::OFS_CH0, 32'h0);
    chk("ch0", rd & 32'h7, run[0] | (cont[0] << 2));
    apb(0, tmr_pkg::OFS_CH1, 32'h0);
    chk("run1", rd & 32'h1, run[1]);
    chk("tog", toggle_output_pin, tog);
    chk("ntog", inverted_toggle_pin, tog ^ 1);
    chk("uf0", seen0, uf[0]);
    chk("uf1", seen1, uf[1]);
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h8fa9dc64));
    rld = '{255, 255};
    repeat (10) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    apb(0, tmr_pkg::OFS_RELOAD, 32'h0);
    chk("rld", rd, 32'h0000FFFF);
    apb(0, 12'h014, 32'h0);
    chk("err", err, 32'h1);
    chk("bad", rd, 32'h0);
    apb(1, tmr_pkg::OFS_COUNT, 32'h55);
    mcmp();
    $display("Test reset done");
    wrld(2, $urandom % 4);
    wctrl(4'h8);
    wch(0, 8'h02);
    wch(1, 8'h02);
    mcmp();
    wch(0, 8'h05);
    pl(0, 5);
    mcmp();
    wch(0, 8'h04);
    pl(0, 3);
    mcmp();
    wch(1, 8'h05);
    pl(1, 6);
    mcmp();
    wch(0, 8'h05);
    pl(0, 2);
    mcmp();
    // Clock enable low freezes the count while the source keeps pulsing
    ce <= 1'h0;
    osc_event_source_i.pulse(0, 3);
    ce <= 1'h1;
    mcmp();
    $display("Test continuous done");
    wch(1, 8'h00);
    wch(0, 8'h03);
    pl(0, 4);
    mcmp();
    wch(0, 8'h01);
    pl(0, 1);
    mcmp();
    $display("Test one-shot done");
    for (int k = 0; k < 4; k++) begin
      wch(0, 8'(8'h07 | (k << 3)));
      pl(0, 2 << (2 * k));
      mcmp();
    end
    wch(0, 8'h0D);
    pl(0, 2);
    wch(0, 8'h0C);
    pl(0, 4);
    wch(0, 8'h0D);
    pl(0, 2);
    mcmp();
    wctrl(4'hE);
    wch(1, 8'h07);
    pl(1, 5);
    pl(0, 3);
    mcmp();
    $display("Test prescale done");
    wch(0, 8'h00);
    wch(1, 8'h18);
    wrld(0, 1);
    wctrl(4'h1);
    wch(0, 8'h03);
    wch(1, 8'h01);
    pl(0, 1);
    mcmp();
    pl(0, 256);
    mcmp();
    $display("Test cascade done");
    wctrl(4'h0);
    wrld(5, 1);
    wch(0, 8'h87);
    osc_event_source_i.level(0, 8);
    mtick(0);
    osc_event_source_i.level(1, 8);
    pl(0, 4);
    mcmp();
    wch(0, 8'hA5);
    osc_event_source_i.level(0, 8);
    osc_event_source_i.level(1, 8);
    mtick(0);
    mcmp();
    wch(0, 8'hC4);
    pl(0, 6);
    wch(0, 8'hC5);
    osc_event_source_i.level(0, 0);
    pl(0, 6);
    mtick(0);
    osc_event_source_i.level(1, 2);
    osc_event_source_i.level(0, 0);
    pl(0, 6);
    mcmp();
    $display("Test event done");
    wrap_up();
  end
endmodule
